// ### design/hrp_pkg.sv
// Shared constants and helpers for the host register port and its host end
package hrp_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 22;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned LANES = 4;

	// ------------------------------------------------------------
	// Address map (word addresses)
	// ------------------------------------------------------------
	localparam int unsigned RSV_LSB = 8;
	localparam logic [21:0] FRAME_WORD_ADDR = 22'h00_0100;

	// ------------------------------------------------------------
	// Frame control words
	// ------------------------------------------------------------
	localparam int unsigned LEN_MODE_BIT = 31;
	localparam int unsigned LEN_W = 16;
	localparam int unsigned DMASK_LSB = 1;
	localparam int unsigned DMASK_W = 24;
	localparam logic [15:0] CRC_BYTES = 16'h0004;
	localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;

	// ------------------------------------------------------------
	// Reset values and bus idle levels
	// ------------------------------------------------------------
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [3:0] PAR_RST = 4'h0;
	localparam logic [31:0] BUS_IDLE = 32'hFFFF_FFFF;
	localparam logic [3:0] PAR_IDLE = 4'hF;

	// Odd parity per byte: lane k covers bits 8k+7..8k
	function automatic logic [3:0] hrp_par(input logic [31:0] w);
		logic [3:0] p;
		p = 4'h0;
		for (int k = 0; k < 4; k++) begin
			p[k] = ~^w[8*k +: 8];
		end
		return p;
	endfunction

endpackage

// ### design/hrp_bus_if.sv
// Pin-level carrier joining the device end and the host end
`timescale 1ns/100ps
interface hrp_bus_if;
	import hrp_pkg::*;

	logic [21:0] addr;
	logic rd_wr;
	logic cs_n;
	logic request_strobe_n;
	logic [31:0] host_data;
	logic [3:0] host_par;
	logic host_drive_n;
	logic [31:0] dev_data;
	logic [3:0] dev_par;
	logic dev_drive_n;
	logic transfer_ack_n;
	logic data_error_out;
	logic interrupt_request_n;
	logic transmit_word_ready;

	// ------------------------------------------------------------
	// Resolved shared data and parity lanes, pulled high when idle
	// ------------------------------------------------------------
	logic [31:0] data_bus;
	logic [3:0] byte_parity_lanes;
	assign data_bus = !host_drive_n ? host_data : (!dev_drive_n ? dev_data : BUS_IDLE);
	assign byte_parity_lanes = !host_drive_n ? host_par : (!dev_drive_n ? dev_par : PAR_IDLE);

	modport dev (
		input addr, rd_wr, cs_n, request_strobe_n, data_bus, byte_parity_lanes,
		output dev_data, dev_par, dev_drive_n, transfer_ack_n, data_error_out,
		output interrupt_request_n, transmit_word_ready
	);

	modport host (
		input data_bus, byte_parity_lanes, transfer_ack_n, data_error_out,
		input interrupt_request_n, transmit_word_ready,
		output addr, rd_wr, cs_n, request_strobe_n, host_data, host_par, host_drive_n
	);

endinterface

// ### design/hrp_dev_end.sv
// Device end of the host register port: handshake, arbiter, parity, frame CRC
`timescale 1ns/100ps
module hrp_dev_end (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	hrp_bus_if.dev bus,
	output logic mgmt_req_o,
	output logic mgmt_we_o,
	output logic [hrp_pkg::ADDR_W-1:0] mgmt_addr_o,
	output logic [hrp_pkg::DATA_W-1:0] mgmt_wdata_o,
	input wire logic [hrp_pkg::DATA_W-1:0] mgmt_rdata_i,
	input wire logic mgmt_ack_i,
	input wire logic boot_req_i,
	input wire logic jtag_req_i,
	output logic boot_gnt_o,
	output logic jtag_gnt_o,
	output logic host_port_hold_flag_o,
	input wire logic irq_i,
	input wire logic crc_enable_i,
	input wire logic frame_ready_i,
	output logic frame_valid_o,
	output logic [hrp_pkg::DATA_W-1:0] frame_data_o,
	output logic frame_last_o,
	output logic frame_lookup_o
);
	import hrp_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_ACK} hrp_dev_st_type;

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	hrp_dev_st_type st_q, st_d;
	logic rsv_rd_q;
	logic boot_gnt_q, jtag_gnt_q;
	logic mgmt_req_q, mgmt_we_q;
	logic [21:0] mgmt_addr_q;
	logic [31:0] mgmt_wdata_q;
	logic ack_q, data_error_out_q, drive_q, hold_q, irq_n_q, transmit_word_ready_q;
	logic [31:0] rdata_q, rdata_d;
	logic [3:0] rpar_q;

	wire req_w = !bus.cs_n && !bus.request_strobe_n;
	wire rd_w = bus.rd_wr;
	wire rsv_w = (bus.addr[21:RSV_LSB] == '0);
	wire frm_w = (bus.addr == FRAME_WORD_ADDR);
	wire par_ok_w = (bus.byte_parity_lanes == hrp_par(bus.data_bus));
	wire host_ok_w = !boot_req_i && !jtag_req_i && !boot_gnt_q && !jtag_gnt_q;
	wire host_busy_w = (st_q == ST_READ && !rsv_rd_q) || mgmt_req_q;
	wire take_w = (st_q == ST_IDLE) && req_w;
	// Writes to managed space wait for the bus; reserved and frame writes do not
	wire wr_go_w = take_w && !rd_w && (rsv_w || frm_w || host_ok_w);
	wire rd_go_w = take_w && rd_w && (rsv_w || host_ok_w);
	wire mwr_w = wr_go_w && !rsv_w && !frm_w && par_ok_w;
	wire fwr_w = wr_go_w && frm_w && par_ok_w;
	wire rd_done_w = (st_q == ST_READ) && (rsv_rd_q || mgmt_ack_i);

	// ------------------------------------------------------------
	// Transaction state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		rdata_d = rdata_q;
		unique case (st_q)
			ST_IDLE: begin
				if (wr_go_w) begin
					st_d = ST_ACK;
				end else if (rd_go_w) begin
					st_d = ST_READ;
				end
			end
			ST_READ: begin
				if (rd_done_w) begin
					st_d = ST_ACK;
					rdata_d = rsv_rd_q ? {31'd0, hold_q} : mgmt_rdata_i;
				end
			end
			ST_ACK: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_q <= ST_IDLE;
			rsv_rd_q <= 1'b0;
			rdata_q <= DATA_RST;
			rpar_q <= PAR_RST;
			ack_q <= 1'b0;
			data_error_out_q <= 1'b0;
			drive_q <= 1'b0;
		end else begin
			st_q <= st_d;
			rdata_q <= rdata_d;
			rpar_q <= hrp_par(rdata_d);
			if (rd_go_w) begin
				rsv_rd_q <= rsv_w;
			end
			ack_q <= (st_d == ST_ACK);
			data_error_out_q <= wr_go_w && !par_ok_w;
			drive_q <= (st_q == ST_READ) && rd_done_w;
		end
	end

	// ------------------------------------------------------------
	// Management bus master and fixed-priority arbiter
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			boot_gnt_q <= 1'b0;
			jtag_gnt_q <= 1'b0;
			hold_q <= 1'b0;
			mgmt_req_q <= 1'b0;
			mgmt_we_q <= 1'b0;
			mgmt_addr_q <= '0;
			mgmt_wdata_q <= DATA_RST;
		end else begin
			boot_gnt_q <= boot_req_i && !host_busy_w;
			jtag_gnt_q <= jtag_req_i && !boot_req_i && !host_busy_w;
			hold_q <= !host_ok_w;
			if (mwr_w || (rd_go_w && !rsv_w)) begin
				mgmt_req_q <= 1'b1;
				mgmt_we_q <= mwr_w;
				mgmt_addr_q <= bus.addr;
				mgmt_wdata_q <= bus.data_bus;
			end else if (mgmt_we_q || mgmt_ack_i) begin
				// Writes are posted for one cycle; reads hold until answered
				mgmt_req_q <= 1'b0;
				mgmt_we_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Frame word path with CRC replacement
	// ------------------------------------------------------------
	logic [1:0] fword_q;
	logic [15:0] flen_q, fcnt_q;
	logic fdir_q;
	logic [31:0] crc_q, crc_w, fout_w;
	logic fvalid_q, flast_q, flook_q;
	logic [31:0] fdata_q;
	logic [15:0] pos_w;
	logic [1:0] k_w;
	logic fb_w;
	logic [7:0] byte_w;

	wire [15:0] body_w = flen_q - CRC_BYTES;
	wire [15:0] fcnt_nx_w = fcnt_q + 16'h0004;
	wire last_w = (fcnt_nx_w >= flen_q);

	always_comb begin
		crc_w = crc_q;
		fout_w = bus.data_bus;
		pos_w = fcnt_q;
		k_w = 2'd0;
		fb_w = 1'b0;
		byte_w = 8'h00;
		// Byte 0 sits in the top lane: big-endian frame order
		for (int b = 0; b < 4; b++) begin
			pos_w = fcnt_q + 16'(b);
			byte_w = bus.data_bus[31-8*b -: 8];
			if (pos_w < body_w) begin
				for (int i = 0; i < 8; i++) begin
					fb_w = crc_w[0] ^ byte_w[i];
					crc_w = (crc_w >> 1) ^ (fb_w ? CRC_POLY : 32'h0000_0000);
				end
			end else if (crc_enable_i && pos_w < flen_q) begin
				k_w = 2'(pos_w - body_w);
				fout_w[31-8*b -: 8] = ~crc_w[{k_w, 3'b000} +: 8];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			fword_q <= 2'd0;
			flen_q <= '0;
			fcnt_q <= '0;
			fdir_q <= 1'b0;
			crc_q <= CRC_INIT;
			fvalid_q <= 1'b0;
			flast_q <= 1'b0;
			flook_q <= 1'b0;
			fdata_q <= DATA_RST;
		end else begin
			fvalid_q <= 1'b0;
			flast_q <= 1'b0;
			if (fwr_w) begin
				unique case (fword_q)
					2'd0: begin
						flen_q <= bus.data_bus[LEN_W-1:0];
						fdir_q <= bus.data_bus[LEN_MODE_BIT];
						fcnt_q <= '0;
						crc_q <= CRC_INIT;
						fword_q <= 2'd1;
					end
					2'd1: begin
						flook_q <= !fdir_q && (bus.data_bus[DMASK_LSB +: DMASK_W] == '0);
						fword_q <= 2'd2;
					end
					default: begin
						fvalid_q <= 1'b1;
						fdata_q <= fout_w;
						flast_q <= last_w;
						crc_q <= crc_w;
						fcnt_q <= fcnt_nx_w;
						if (last_w) begin
							fword_q <= 2'd0;
						end
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Side-band outputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			irq_n_q <= 1'b1;
			transmit_word_ready_q <= 1'b0;
		end else begin
			irq_n_q <= !irq_i;
			transmit_word_ready_q <= frame_ready_i;
		end
	end

	assign bus.transfer_ack_n = !ack_q;
	assign bus.data_error_out = data_error_out_q;
	assign bus.dev_data = rdata_q;
	assign bus.dev_par = rpar_q;
	assign bus.dev_drive_n = !drive_q;
	assign bus.interrupt_request_n = irq_n_q;
	assign bus.transmit_word_ready = transmit_word_ready_q;
	assign mgmt_req_o = mgmt_req_q;
	assign mgmt_we_o = mgmt_we_q;
	assign mgmt_addr_o = mgmt_addr_q;
	assign mgmt_wdata_o = mgmt_wdata_q;
	assign boot_gnt_o = boot_gnt_q;
	assign jtag_gnt_o = jtag_gnt_q;
	assign host_port_hold_flag_o = hold_q;
	assign frame_valid_o = fvalid_q;
	assign frame_data_o = fdata_q;
	assign frame_last_o = flast_q;
	assign frame_lookup_o = flook_q;

endmodule

// ### design/hrp_host_end.sv
// Host end of the host register port: issues one word request at a time
`timescale 1ns/100ps
module hrp_host_end (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	hrp_bus_if.host bus,
	input wire logic cmd_valid_i,
	input wire logic cmd_read_i,
	input wire logic [hrp_pkg::ADDR_W-1:0] cmd_addr_i,
	input wire logic [hrp_pkg::DATA_W-1:0] cmd_wdata_i,
	input wire logic cmd_bad_par_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [hrp_pkg::DATA_W-1:0] rsp_rdata_o,
	output logic rsp_error_o,
	output logic irq_o,
	output logic tx_ready_o
);
	import hrp_pkg::*;

	typedef enum logic {HS_IDLE, HS_WAIT} hrp_host_st_type;

	hrp_host_st_type st_q;
	logic strobe_n_q, rd_q, drive_n_q, rsp_q, err_q, irq_q, transmit_word_ready_q, ready_q;
	logic [3:0] par_q;
	logic [21:0] addr_q;
	logic [31:0] wdata_q, rdata_q;

	wire start_w = (st_q == HS_IDLE) && cmd_valid_i;
	// No timeout: the request stands until the device answers
	wire ack_w = (st_q == HS_WAIT) && !bus.transfer_ack_n;
	wire rpar_bad_w = rd_q && (bus.byte_parity_lanes != hrp_par(bus.data_bus));

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_q <= HS_IDLE;
			strobe_n_q <= 1'b1;
			rd_q <= 1'b1;
			drive_n_q <= 1'b1;
			addr_q <= '0;
			wdata_q <= DATA_RST;
			rdata_q <= DATA_RST;
			rsp_q <= 1'b0;
			err_q <= 1'b0;
			irq_q <= 1'b0;
			transmit_word_ready_q <= 1'b0;
			ready_q <= 1'b1;
			par_q <= PAR_RST;
		end else begin
			rsp_q <= 1'b0;
			irq_q <= !bus.interrupt_request_n;
			transmit_word_ready_q <= bus.transmit_word_ready;
			if (start_w) begin
				st_q <= HS_WAIT;
				strobe_n_q <= 1'b0;
				rd_q <= cmd_read_i;
				drive_n_q <= cmd_read_i;
				addr_q <= cmd_addr_i;
				wdata_q <= cmd_wdata_i;
				ready_q <= 1'b0;
				// Optional flip of one lane lets a test host send a bad word
				par_q <= hrp_par(cmd_wdata_i) ^ {3'b000, cmd_bad_par_i};
			end else if (ack_w) begin
				st_q <= HS_IDLE;
				ready_q <= 1'b1;
				strobe_n_q <= 1'b1;
				drive_n_q <= 1'b1;
				rsp_q <= 1'b1;
				rdata_q <= rd_q ? bus.data_bus : wdata_q;
				err_q <= bus.data_error_out || rpar_bad_w;
			end
		end
	end

	assign bus.addr = addr_q;
	assign bus.rd_wr = rd_q;
	assign bus.cs_n = strobe_n_q;
	assign bus.request_strobe_n = strobe_n_q;
	assign bus.host_data = wdata_q;
	assign bus.host_par = par_q;
	assign bus.host_drive_n = drive_n_q;
	assign cmd_ready_o = ready_q;
	assign rsp_valid_o = rsp_q;
	assign rsp_rdata_o = rdata_q;
	assign rsp_error_o = err_q;
	assign irq_o = irq_q;
	assign tx_ready_o = transmit_word_ready_q;

endmodule

// ### sim/hrp_bus_props.sv
// Pin-level protocol checks on the host register port carrier
`timescale 1ns/100ps
module hrp_bus_props (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [21:0] addr,
	input wire logic rd_wr,
	input wire logic cs_n,
	input wire logic request_strobe_n,
	input wire logic host_drive_n,
	input wire logic dev_drive_n,
	input wire logic [31:0] data_bus,
	input wire logic [3:0] byte_parity_lanes,
	input wire logic transfer_ack_n,
	input wire logic data_error_out
);
	import hrp_pkg::*;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	logic rsv;
	assign rsv = addr[21:8] == 14'h0000;

	property p_ack_one;
		!transfer_ack_n |=> transfer_ack_n;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_ack_pend;
		!transfer_ack_n |-> !request_strobe_n && !cs_n;
	endproperty
	a_ack_pend: assert property (p_ack_pend) else $error("ack without request");
	property p_wr_next;
		$fell(request_strobe_n) && !rd_wr && rsv |=> !transfer_ack_n;
	endproperty
	a_wr_next: assert property (p_wr_next) else $error("write ack late");
	property p_rd_min;
		$fell(request_strobe_n) && rd_wr |=> transfer_ack_n;
	endproperty
	a_rd_min: assert property (p_rd_min) else $error("read acked too soon");
	property p_rsv_rd;
		$fell(request_strobe_n) && rd_wr && rsv |=> ##1
			(!transfer_ack_n && !dev_drive_n && data_bus[31:1] == 31'h0000_0000);
	endproperty
	a_rsv_rd: assert property (p_rsv_rd) else $error("bad low range read");
	property p_err_ack;
		data_error_out |-> !transfer_ack_n && !rd_wr;
	endproperty
	a_err_ack: assert property (p_err_ack) else $error("error flag off ack");
	property p_drive_rd;
		!dev_drive_n |-> !transfer_ack_n && rd_wr && host_drive_n;
	endproperty
	a_drive_rd: assert property (p_drive_rd) else $error("device drives outside read ack");
	property p_rd_par;
		!dev_drive_n |-> byte_parity_lanes == {~^data_bus[31:24], ~^data_bus[23:16],
			~^data_bus[15:8], ~^data_bus[7:0]};
	endproperty
	a_rd_par: assert property (p_rd_par) else $error("read parity wrong");
	property p_hold_req;
		$rose(request_strobe_n) |-> $past(!transfer_ack_n);
	endproperty
	a_hold_req: assert property (p_hold_req) else $error("strobe dropped before ack");
endmodule

// ### sim/tb_host_register_port_with_mgmt_arbiter.sv
// Testbench joining the device end and the host end of the host register port
`timescale 1ns/100ps
module tb_host_register_port_with_mgmt_arbiter;
	import hrp_pkg::*;
	logic sys_clk, srst, cv, crd, m_ack, boot_req, jtag_req, irq, crc_en, f_rdy, m_req, m_we;
	logic bg, jg, hold, fv, fl, flk, rv, rerr, irq_o, txr, dn, rdy, bpar;
	logic [7:0] lat;
	logic [4:0] idle_v;
	logic [21:0] ca, m_a, got_a, a;
	logic [31:0] cw, m_rd, m_wd, rdat, fd, got_w, w;
	logic [15:0] wcnt, n;
	logic [32:0] fq[$];
	int error_cnt, samples_checked;
	int seed = 32'h522f;

	hrp_bus_if bus();
	hrp_dev_end u_hrp_dev_end (.sys_clk_i(sys_clk), .srst_i(srst), .bus(bus.dev),
		.mgmt_req_o(m_req), .mgmt_we_o(m_we), .mgmt_addr_o(m_a), .mgmt_wdata_o(m_wd),
		.mgmt_rdata_i(m_rd), .mgmt_ack_i(m_ack), .boot_req_i(boot_req), .jtag_req_i(jtag_req),
		.boot_gnt_o(bg), .jtag_gnt_o(jg), .host_port_hold_flag_o(hold), .irq_i(irq),
		.crc_enable_i(crc_en), .frame_ready_i(f_rdy), .frame_valid_o(fv), .frame_data_o(fd),
		.frame_last_o(fl), .frame_lookup_o(flk));
	hrp_host_end u_hrp_host_end (.sys_clk_i(sys_clk), .srst_i(srst), .bus(bus.host),
		.cmd_valid_i(cv), .cmd_read_i(crd), .cmd_addr_i(ca), .cmd_wdata_i(cw),
		.cmd_bad_par_i(bpar), .cmd_ready_o(rdy),
		.rsp_valid_o(rv), .rsp_rdata_o(rdat), .rsp_error_o(rerr), .irq_o(irq_o), .tx_ready_o(txr));
	hrp_bus_props u_hrp_bus_props (.sys_clk_i(sys_clk), .srst_i(srst), .addr(bus.addr),
		.rd_wr(bus.rd_wr), .cs_n(bus.cs_n), .request_strobe_n(bus.request_strobe_n),
		.host_drive_n(bus.host_drive_n), .dev_drive_n(bus.dev_drive_n), .data_bus(bus.data_bus),
		.byte_parity_lanes(bus.byte_parity_lanes), .transfer_ack_n(bus.transfer_ack_n),
		.data_error_out(bus.data_error_out));
	assign idle_v = {bus.transfer_ack_n, bus.request_strobe_n, bus.dev_drive_n,
		bus.data_error_out, rdy};

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Management side: reads answered a cycle late, writes and frame words logged
	always @(posedge sys_clk) begin
		if (srst) begin
			m_ack <= 1'b0;
			m_rd <= 32'h0000_0000;
			wcnt <= 16'h0000;
		end else begin
			m_ack <= m_req && !m_we && !m_ack;
			m_rd <= exp_rd(m_a);
			if (m_req && m_we) begin
				wcnt <= wcnt + 16'h0001;
				got_a <= m_a;
				got_w <= m_wd;
			end
		end
		if (fv) begin
			fq.push_back({fl, fd});
		end
	end

	function automatic logic [31:0] exp_rd(input logic [21:0] x);
		return {x[9:0], x} ^ 32'hA5A5_0F0F;
	endfunction

	// Frame check over one payload word, first byte in the top lane
	function automatic logic [31:0] crc_w(input logic [31:0] x);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 0; i < 32; i++) begin
			c = (c >> 1) ^ ((c[0] ^ x[24 - 8 * (i / 8) + i % 8]) ? CRC_POLY : 32'h0000_0000);
		end
		c = ~c;
		return {c[7:0], c[15:8], c[23:16], c[31:24]};
	endfunction

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic rd, input logic [21:0] ad, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge sys_clk);
		cv <= 1'b1;
		crd <= rd;
		ca <= ad;
		cw <= wd;
		@(posedge sys_clk);
		cv <= 1'b0;
		do begin
			@(posedge sys_clk);
			#1;
			k++;
		end while (rv !== 1'b1 && k < 200);
		lat = 8'(k);
		if (k >= 200) begin
			error_cnt++;
		end
	endtask

	task automatic complete_run;
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		complete_run;
	end

	initial begin
		srst = 1'b1;
		{cv, crd, bpar, boot_req, jtag_req, irq, crc_en, f_rdy, dn} = 9'h000;
		ca = 22'h00_0000;
		cw = 32'h0000_0000;
		error_cnt = 0;
		samples_checked = 0;
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		#1 chk(idle_v, 5'b11101);
		repeat (12) begin
			a = {1'b1, 21'($random(seed))};
			w = $random(seed);
			xfer(1'b0, a, w);
			chk(lat, 8'd2);
			chk(got_w, w);
			chk(got_a, a);
			chk(rerr, 1'b0);
			xfer(1'b1, a, 32'h0000_0000);
			chk(rdat, exp_rd(a));
		end
		$display("test managed_rw done");
		n = wcnt;
		xfer(1'b0, 22'h00_00FF, 32'hFFFF_FFFF);
		chk(wcnt, n);
		chk(lat, 8'd2);
		xfer(1'b1, 22'h00_0000, 32'h0000_0000);
		chk(rdat, 32'h0000_0000);
		chk(lat, 8'd3);
		@(posedge sys_clk);
		bpar <= 1'b1;
		n = wcnt;
		xfer(1'b0, 22'h20_0040, 32'h0F0F_0F0F);
		chk(rerr, 1'b1);
		chk(wcnt, n);
		@(posedge sys_clk);
		bpar <= 1'b0;
		$display("test parity done");
		@(posedge sys_clk);
		boot_req <= 1'b1;
		jtag_req <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk({bg, jg, hold}, 3'b101);
		xfer(1'b1, 22'h00_00FF, 32'h0000_0000);
		chk(rdat, 32'h0000_0001);
		@(posedge sys_clk);
		boot_req <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 chk({bg, jg}, 2'b01);
		fork
			begin
				xfer(1'b1, 22'h20_1234, 32'h0000_0000);
				dn = 1'b1;
			end
			begin
				repeat (12) @(posedge sys_clk);
				chk(dn, 1'b0);
				chk(rdy, 1'b0);
				jtag_req <= 1'b0;
			end
		join
		chk(rdat, exp_rd(22'h20_1234));
		$display("test arbitration done");
		@(posedge sys_clk);
		irq <= 1'b1;
		f_rdy <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk({irq_o, txr, bus.interrupt_request_n}, 3'b110);
		$display("test mirrors done");
		xfer(1'b0, FRAME_WORD_ADDR, 32'h0000_0010);
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		#1 chk(idle_v, 5'b11101);
		$display("test reset done");
		for (int e = 0; e < 2; e++) begin
			@(posedge sys_clk);
			crc_en <= e[0];
			w = $random(seed);
			xfer(1'b0, FRAME_WORD_ADDR, 32'h0000_0008);
			xfer(1'b0, FRAME_WORD_ADDR, 32'h0000_0000);
			xfer(1'b0, FRAME_WORD_ADDR, w);
			xfer(1'b0, FRAME_WORD_ADDR, 32'h1234_5678);
			repeat (3) @(posedge sys_clk);
			#1 chk(33'(fq.size()), 33'd2);
			chk(fq[0], {1'b0, w});
			chk(fq[1], {1'b1, e[0] ? crc_w(w) : 32'h1234_5678});
			chk(flk, 1'b1);
			fq.delete();
		end
		$display("test frames done");
		complete_run;
	end
endmodule
